//--- hw/rtcpr_pkg.sv
// rtcpr_pkg: offsets, field positions, reset values, timing and types
// assumes a 200 MHz system clock and a 32.768 kHz low-speed time base
package rtcpr_pkg;

	// =========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_PAGE = 8'h00;
	localparam logic [7:0] OFS_RESET = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_SEC = 8'h10;
	localparam logic [7:0] OFS_MIN = 8'h14;
	localparam logic [7:0] OFS_HOUR = 8'h18;
	localparam logic [7:0] OFS_DAY = 8'h1c;
	localparam logic [7:0] OFS_WDAY = 8'h20;

	// =========================================================
	// field positions
	localparam int unsigned PG_IRQ_EN = 7;
	localparam int unsigned PG_ADJUST = 4;
	localparam int unsigned PG_RUN = 3;
	localparam int unsigned PG_ALM = 2;
	localparam int unsigned PG_PAGE = 0;
	localparam int unsigned RS_DIS1 = 7;
	localparam int unsigned RS_DIS16 = 6;
	localparam int unsigned RS_SECRST = 5;
	localparam int unsigned RS_ALMINIT = 4;
	localparam int unsigned IRQ_EVT = 0;
	localparam int unsigned IRQ_ADJ = 1;
	localparam int unsigned IRQ_SRST = 2;
	localparam int unsigned IRQ_W = 3;

	// =========================================================
	// reset and init values
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] RESET_RST = 8'hc0;
	localparam logic [2:0] LOW3_RST_WR = 3'h7;
	localparam logic [6:0] ALM_MIN_INIT = 7'h00;
	localparam logic [5:0] ALM_HOUR_INIT = 6'h00;
	localparam logic [5:0] ALM_DAY_INIT = 6'h01;
	localparam logic [2:0] ALM_WDAY_INIT = 3'h0;
	localparam logic [5:0] SEC_LAST = 6'h3b;
	localparam logic [5:0] SEC_HALF = 6'h1e;

	// =========================================================
	// timing
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned FS_HZ = 32_768;
	localparam int unsigned FS_DIV_DEF = CLK_HZ / FS_HZ;
	localparam int unsigned PRE_DIV_DEF = FS_HZ;
	localparam int unsigned HZ16_DIV_DEF = FS_HZ / 16;

	// =========================================================
	// types
	typedef struct packed {
		logic [2:0] wday;
		logic [5:0] day;
		logic [5:0] hour;
		logic [6:0] min;
	} rtcpr_time_t;

	typedef struct packed {
		logic pg_irq_en;
		logic pg_adjust;
		logic pg_run;
		logic pg_alm;
		logic pg_page;
		logic rs_dis1;
		logic rs_dis16;
		logic rs_sec_rst;
		logic [2:0] rs_low3;
		rtcpr_time_t alarm;
		logic [12:0] fs_cnt;
		logic [14:0] pre_cnt;
		logic [10:0] h16_cnt;
		logic [5:0] sec;
		logic min_carry;
		logic match_d;
		logic irq_pulse;
		logic [IRQ_W-1:0] sts;
		logic [IRQ_W-1:0] msk;
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
	} rtcpr_state_t;

endpackage : rtcpr_pkg

//--- hw/rtcpr_top.sv
// rtcpr_top: page/enable control, seconds adjust and reset, alarm init,
// interrupt source select, behind an AHB-Lite slave
// assumes inputs synchronous to CLOCK_I; current time supplied from outside
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - adjust request acts only at the next seconds count-up.
// - adjust with seconds 0..29 clears seconds, minutes unchanged.
// - adjust with seconds 30..59 carries a minute and clears seconds.
// - adjust bit reads one while pending; writing zero does nothing.
// - writing one requests prescaler reset (seconds kept), sampled on low-speed clock.
// - seconds reset bit reads one while pending; writing zero does nothing.
// - alarm init loads minute 00, hour 00, day 01, Sunday.
// - source is alarm, 1 Hz or 16 Hz per disable bits and alarm enable.
// - clock-run off stops seconds and carries; prescaler keeps counting.
// - page bit one maps shared addresses to the alarm page.
// - each selected event gives a one low-speed-cycle request pulse while the interrupt enable bit is one.
// - alarm event when current time becomes equal to the alarm registers.
module rtcpr_top
	import rtcpr_pkg::*;
#(
	parameter int unsigned FS_DIV = rtcpr_pkg::FS_DIV_DEF,
	parameter int unsigned PRE_DIV = rtcpr_pkg::PRE_DIV_DEF,
	parameter int unsigned HZ16_DIV = rtcpr_pkg::HZ16_DIV_DEF,
	parameter bit LOW3_WR = 1'b0
)
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// ahb-lite slave
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	// time page values
	input wire rtcpr_pkg::rtcpr_time_t CUR_TIME_I,
	// time and alarm outputs
	output logic [5:0] SEC_O,
	output logic MIN_CARRY_O,
	output rtcpr_pkg::rtcpr_time_t ALARM_TIME_O,
	// interrupts
	output logic CLOCK_IRQ_REQ_O,
	output logic ALARM_N_O,
	output logic IRQ_O
);
	import rtcpr_pkg::*;

	rtcpr_state_t state_r;
	rtcpr_state_t state_nxt;

	localparam logic [12:0] FS_LAST = 13'(FS_DIV - 1);
	localparam logic [14:0] PRE_LAST = 15'(PRE_DIV - 1);
	localparam logic [10:0] H16_LAST = 11'(HZ16_DIV - 1);
	localparam logic [2:0] LOW3_RST = LOW3_WR ? LOW3_RST_WR : 3'h0;

	// =========================================================
	// next-state logic
	always_comb
	begin
		logic fs_tick;
		logic sec_tick;
		logic hz16_tick;
		logic match;
		logic alm_ev;
		logic ev;
		logic [IRQ_W-1:0] sts_set;
		logic [IRQ_W-1:0] sts_clr;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [7:0] ra;
		fs_tick = 1'b0;
		sec_tick = 1'b0;
		hz16_tick = 1'b0;
		match = 1'b0;
		alm_ev = 1'b0;
		ev = 1'b0;
		sts_set = '0;
		sts_clr = '0;
		wd = HWDATA_I[7:0];
		rd = 8'h00;
		ra = HADDR_I[7:0];
		state_nxt = state_r;
		state_nxt.min_carry = 1'b0;

		// low-speed time base and prescaler, free running
		fs_tick = (state_r.fs_cnt == FS_LAST);
		state_nxt.fs_cnt = fs_tick ? 13'h0000 : state_r.fs_cnt + 13'h0001;
		sec_tick = fs_tick && (state_r.pre_cnt == PRE_LAST);
		hz16_tick = fs_tick && (state_r.h16_cnt == H16_LAST);
		if (fs_tick)
		begin
			state_nxt.pre_cnt = sec_tick ? 15'h0000 : state_r.pre_cnt + 15'h0001;
			state_nxt.h16_cnt = hz16_tick ? 11'h000 : state_r.h16_cnt + 11'h001;
		end

		if (sec_tick && state_r.pg_run)
		begin
			if (state_r.pg_adjust)
			begin
				state_nxt.sec = 6'h00;
				state_nxt.min_carry = (state_r.sec >= SEC_HALF);
				state_nxt.pg_adjust = 1'b0;
				sts_set[IRQ_ADJ] = 1'b1;
			end
			else if (state_r.sec == SEC_LAST)
			begin
				state_nxt.sec = 6'h00;
				state_nxt.min_carry = 1'b1;
			end
			else
			begin
				state_nxt.sec = state_r.sec + 6'h01;
			end
		end

		if (fs_tick && state_r.rs_sec_rst)
		begin
			state_nxt.pre_cnt = 15'h0000;
			state_nxt.rs_sec_rst = 1'b0;
			sts_set[IRQ_SRST] = 1'b1;
		end

		match = (state_r.alarm == CUR_TIME_I);
		if (fs_tick)
		begin
			state_nxt.match_d = match;
		end
		alm_ev = match && !state_r.match_d;

		unique case ({state_r.rs_dis1, state_r.rs_dis16, state_r.pg_alm})
			3'b111: ev = alm_ev;
			3'b010: ev = sec_tick;
			3'b100: ev = hz16_tick;
			default: ev = 1'b0;
		endcase
		ev = ev && fs_tick && state_r.pg_irq_en;
		if (fs_tick)
		begin
			state_nxt.irq_pulse = ev;
		end
		sts_set[IRQ_EVT] = ev;

		// bus data phase write
		if (state_r.dp_valid && state_r.dp_write)
		begin
			unique case (state_r.dp_addr)
				OFS_PAGE:
				begin
					state_nxt.pg_irq_en = wd[PG_IRQ_EN];
					if (wd[PG_ADJUST])
					begin
						state_nxt.pg_adjust = 1'b1;
					end
					state_nxt.pg_run = wd[PG_RUN];
					state_nxt.pg_alm = wd[PG_ALM];
					state_nxt.pg_page = wd[PG_PAGE];
				end
				OFS_RESET:
				begin
					state_nxt.rs_dis1 = wd[RS_DIS1];
					state_nxt.rs_dis16 = wd[RS_DIS16];
					if (wd[RS_SECRST])
					begin
						state_nxt.rs_sec_rst = 1'b1;
					end
					if (wd[RS_ALMINIT])
					begin
						state_nxt.alarm.min = ALM_MIN_INIT;
						state_nxt.alarm.hour = ALM_HOUR_INIT;
						state_nxt.alarm.day = ALM_DAY_INIT;
						state_nxt.alarm.wday = ALM_WDAY_INIT;
					end
					if (LOW3_WR)
					begin
						state_nxt.rs_low3 = wd[2:0];
					end
				end
				OFS_STAT: sts_clr = wd[IRQ_W-1:0];
				OFS_MASK: state_nxt.msk = wd[IRQ_W-1:0];
				// alarm page writable only on page one
				OFS_MIN:
				begin
					if (state_r.pg_page)
					begin
						state_nxt.alarm.min = wd[6:0];
					end
				end
				OFS_HOUR:
				begin
					if (state_r.pg_page)
					begin
						state_nxt.alarm.hour = wd[5:0];
					end
				end
				OFS_DAY:
				begin
					if (state_r.pg_page)
					begin
						state_nxt.alarm.day = wd[5:0];
					end
				end
				OFS_WDAY:
				begin
					if (state_r.pg_page)
					begin
						state_nxt.alarm.wday = wd[2:0];
					end
				end
				default: state_nxt.msk = state_r.msk;
			endcase
		end

		// sticky status, set beats clear
		state_nxt.sts = (state_r.sts & ~sts_clr) | sts_set;

		// address phase capture
		state_nxt.dp_valid = HSEL_I && HREADY_I && HTRANS_I[1] && (HADDR_I[31:8] == 24'h000000);
		state_nxt.dp_write = HWRITE_I;
		state_nxt.dp_addr = ra;

		// read mux on next values so a write just before is seen
		unique case (ra)
			OFS_PAGE: rd = {state_nxt.pg_irq_en, 2'b00, state_nxt.pg_adjust,
				state_nxt.pg_run, state_nxt.pg_alm, 1'b0, state_nxt.pg_page};
			OFS_RESET: rd = {state_nxt.rs_dis1, state_nxt.rs_dis16, state_nxt.rs_sec_rst,
				2'b00, state_nxt.rs_low3};
			OFS_STAT: rd = {5'h00, state_nxt.sts};
			OFS_MASK: rd = {5'h00, state_nxt.msk};
			OFS_SEC: rd = state_nxt.pg_page ? 8'h00 : {2'b00, state_nxt.sec};
			OFS_MIN: rd = {1'b0, state_nxt.pg_page ? state_nxt.alarm.min : CUR_TIME_I.min};
			OFS_HOUR: rd = {2'b00, state_nxt.pg_page ? state_nxt.alarm.hour : CUR_TIME_I.hour};
			OFS_DAY: rd = {2'b00, state_nxt.pg_page ? state_nxt.alarm.day : CUR_TIME_I.day};
			OFS_WDAY: rd = {5'h00, state_nxt.pg_page ? state_nxt.alarm.wday : CUR_TIME_I.wday};
			default: rd = 8'h00;
		endcase
		if (state_nxt.dp_valid && !HWRITE_I)
		begin
			state_nxt.rdata = {24'h000000, rd};
		end
		else
		begin
			state_nxt.rdata = 32'h00000000;
		end
	end

	// =========================================================
	// state register
	always_ff @(posedge CLOCK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			state_r <= '0;
			state_r.pg_irq_en <= PAGE_RST[PG_IRQ_EN];
			state_r.pg_run <= PAGE_RST[PG_RUN];
			state_r.pg_alm <= PAGE_RST[PG_ALM];
			state_r.pg_page <= PAGE_RST[PG_PAGE];
			state_r.rs_dis1 <= RESET_RST[RS_DIS1];
			state_r.rs_dis16 <= RESET_RST[RS_DIS16];
			state_r.rs_low3 <= LOW3_RST;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// =========================================================
	// outputs
	assign HRDATA_O = state_r.rdata;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	assign SEC_O = state_r.sec;
	assign MIN_CARRY_O = state_r.min_carry;
	assign ALARM_TIME_O = state_r.alarm;
	assign CLOCK_IRQ_REQ_O = state_r.irq_pulse;
	assign ALARM_N_O = ~state_r.irq_pulse;
	assign IRQ_O = |(state_r.sts & state_r.msk);

endmodule : rtcpr_top

//--- tb/rtcpr_top_monitor.sv
// rtcpr_top_monitor: port-level assertions for rtcpr_top
// assumes HREADY_I is fed from HREADYOUT_O (single slave)
`timescale 1ns/1ps
module rtcpr_top_monitor
	import rtcpr_pkg::*;
#(
	parameter int unsigned FS_DIV = rtcpr_pkg::FS_DIV_DEF
)
(
	// clock, reset, bus
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	// time and interrupt outputs
	input wire logic [5:0] SEC_O,
	input wire logic MIN_CARRY_O,
	input wire rtcpr_pkg::rtcpr_time_t ALARM_TIME_O,
	input wire logic CLOCK_IRQ_REQ_O,
	input wire logic ALARM_N_O
);
	logic wr_d;
	logic [31:0] a_d;
	logic [15:0] hi_cnt;
	// data-phase tracking and request pulse width
	always_ff @(posedge CLOCK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			wr_d <= 1'b0;
			a_d <= 32'h0;
			hi_cnt <= 16'h0;
		end
		else
		begin
			wr_d <= HSEL_I && HTRANS_I[1] && HWRITE_I && HREADYOUT_O;
			a_d <= HADDR_I;
			hi_cnt <= CLOCK_IRQ_REQ_O ? hi_cnt + 16'h1 : 16'h0;
		end
	end
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_B_I);
	bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
	else $error("bus not ready or not okay");
	read_upper_a: assert property (HRDATA_O[31:8] == 24'h0)
	else $error("upper read data not zero");
	sec_range_a: assert property (SEC_O <= SEC_LAST)
	else $error("seconds above last value");
	sec_step_a: assert property ($changed(SEC_O) |-> SEC_O == 6'h00 || SEC_O == $past(SEC_O) + 6'h01)
	else $error("seconds moved other than step or clear");
	carry_cause_a: assert property (MIN_CARRY_O |-> SEC_O == 6'h00 &&
		($past(SEC_O) >= SEC_HALF || $past(SEC_O, 2) >= SEC_HALF))
	else $error("minute carry without upper half seconds");
	carry_pulse_a: assert property (MIN_CARRY_O |=> !MIN_CARRY_O)
	else $error("minute carry longer than one cycle");
	alarm_pin_a: assert property (ALARM_N_O == !CLOCK_IRQ_REQ_O)
	else $error("alarm pin not inverse of request");
	req_width_a: assert property ($fell(CLOCK_IRQ_REQ_O) |-> hi_cnt == FS_DIV)
	else $error("request pulse width wrong");
	req_long_a: assert property (hi_cnt <= FS_DIV)
	else $error("request pulse too long");
	alarm_init_a: assert property (wr_d && a_d == 32'(OFS_RESET) && HWDATA_I[RS_ALMINIT] |=>
		ALARM_TIME_O == {ALM_WDAY_INIT, ALM_DAY_INIT, ALM_HOUR_INIT, ALM_MIN_INIT})
	else $error("alarm init values wrong");
endmodule : rtcpr_top_monitor

bind rtcpr_top rtcpr_top_monitor #(.FS_DIV(FS_DIV)) i_rtcpr_top_monitor (.CLOCK_I, .RST_B_I, .HSEL_I,
	.HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .SEC_O, .MIN_CARRY_O,
	.ALARM_TIME_O, .CLOCK_IRQ_REQ_O, .ALARM_N_O);

//--- tb/tb_rtcpr_page_and_reset_control.sv
// tb_rtcpr_page_and_reset_control: self-checking bench for rtcpr_top
// assumes shortened dividers: tick every 4 clocks, 1 Hz every 64, 16 Hz every 16
`timescale 1ns/1ps
module tb_rtcpr_page_and_reset_control
	import rtcpr_pkg::*;
();
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	rtcpr_time_t cur = '0;
	logic hr_s;
	logic [31:0] rd_s;
	int carry = 0;
	int c0;
	int fail_count = 0;
	int comparisons = 0;
	logic [31:0] q;
	int t;
	wire [31:0] hrdata;
	wire hready;
	wire min_carry;
	wire irq;
	wire [5:0] sec;
	wire rtcpr_time_t alm;
	logic [7:0] ra [5] = '{OFS_PAGE, OFS_RESET, OFS_STAT, OFS_MASK, 8'h24};
	logic [31:0] rv [5] = '{32'h0, 32'hc0, 32'h0, 32'h0, 32'h0};
	logic [7:0] fm [4] = '{8'h7f, 8'h3f, 8'h3f, 8'h07};
	logic [31:0] iv [4] = '{32'h0, 32'h0, 32'h1, 32'h0};
	logic [7:0] cf [4] = '{8'hc0, 8'h40, 8'h80, 8'h00};
	logic [7:0] pg [4] = '{8'h04, 8'h00, 8'h00, 8'h00};
	int wn [4] = '{100, 200, 20, 200};
	logic [31:0] mk [4] = '{32'h1, 32'h1, 32'h0, 32'h1};

	rtcpr_top #(.FS_DIV(4), .PRE_DIV(16), .HZ16_DIV(4)) i_rtcpr_top (.CLOCK_I(clk), .RST_B_I(rst_b),
		.HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
		.CUR_TIME_I(cur), .SEC_O(sec), .MIN_CARRY_O(min_carry), .ALARM_TIME_O(alm),
		.CLOCK_IRQ_REQ_O(), .ALARM_N_O(), .IRQ_O(irq));

	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// settled outputs, taken before each rising edge
	always @(negedge clk)
	begin
		hr_s = hready;
		rd_s = hrdata;
	end
	always @(posedge clk)
		if (min_carry === 1'b1)
			carry <= carry + 1;

	// =========================================================
	// bus cycles and comparison
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hr_s !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hr_s !== 1'b1);
		r = rd_s;
	endtask : bus
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	// expected event per disable bits and alarm enable
	function automatic logic [31:0] src_ev(input logic [7:0] c, input logic [7:0] p);
		return 32'({c[RS_DIS1], c[RS_DIS16], p[PG_ALM]} inside {3'b111, 3'b010, 3'b100});
	endfunction : src_ev
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rchk
	task automatic final_report();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	initial
	begin
		#150000;
		fail_count++;
		final_report();
	end

	// =========================================================
	// scenarios
	initial
	begin
		void'($urandom(32'h902e1aac));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		foreach (ra[i]) rchk(ra[i], rv[i]);
		wr(OFS_PAGE, 32'h62);
		rchk(OFS_PAGE, 32'h0);
		wr(OFS_PAGE, 32'h01);
		for (int i = 0; i < 4; i++)
		begin
			q = $urandom() & 32'(fm[i]);
			wr(OFS_MIN + 8'(4 * i), q);
			rchk(OFS_MIN + 8'(4 * i), q);
		end
		wr(OFS_RESET, 32'hdf);
		rchk(OFS_RESET, 32'hc0);
		foreach (iv[i]) rchk(OFS_MIN + 8'(4 * i), iv[i]);
		chk(32'(alm), 32'({ALM_WDAY_INIT, ALM_DAY_INIT, ALM_HOUR_INIT, ALM_MIN_INIT}));
		cur <= 22'($urandom());
		wr(OFS_PAGE, 32'h00);
		rchk(OFS_MIN, 32'(cur.min));
		rchk(OFS_WDAY, 32'(cur.wday));
		for (int k = 0; k < 4; k++)
		begin
			cur <= '0;
			wr(OFS_MASK, mk[k]);
			wr(OFS_RESET, 32'(cf[k]));
			wr(OFS_PAGE, 32'(pg[k]));
			wr(OFS_PAGE, 32'(pg[k] | 8'h80));
			cur <= {ALM_WDAY_INIT, ALM_DAY_INIT, ALM_HOUR_INIT, ALM_MIN_INIT};
			for (int i = 0; i < wn[k] && irq !== 1'b1; i++) @(negedge clk);
			chk(32'(irq), src_ev(cf[k], pg[k]) & mk[k]);
			@(posedge clk);
			rchk(OFS_STAT, src_ev(cf[k], pg[k]));
			wr(OFS_PAGE, 32'(pg[k]));
			wr(OFS_PAGE, 32'h00);
			wr(OFS_STAT, 32'h7);
			@(negedge clk);
			chk(32'(irq), 32'h0);
			@(posedge clk);
		end
		wr(OFS_RESET, 32'hc0);
		wr(OFS_PAGE, 32'h08);
		for (int k = 0; k < 2; k++)
		begin
			t = k ? 31 + $urandom() % 27 : 1 + $urandom() % 27;
			while (sec !== 6'(t)) @(negedge clk);
			@(posedge clk);
			c0 = carry;
			wr(OFS_PAGE, 32'h18);
			wr(OFS_PAGE, 32'h08);
			rchk(OFS_PAGE, 32'h18);
			do bus(1'b0, OFS_PAGE, 32'h0, q); while (q[PG_ADJUST] === 1'b1);
			@(negedge clk);
			chk(32'(sec), 32'h0);
			chk(32'(carry - c0), 32'(k));
			@(posedge clk);
		end
		wr(OFS_PAGE, 32'h00);
		@(negedge clk);
		t = sec;
		repeat (150) @(negedge clk);
		chk(32'(sec), 32'(t));
		@(posedge clk);
		wr(OFS_STAT, 32'h7);
		wr(OFS_RESET, 32'he0);
		repeat (10) @(posedge clk);
		rchk(OFS_RESET, 32'hc0);
		rchk(OFS_STAT, 32'h4);
		final_report();
	end
endmodule : tb_rtcpr_page_and_reset_control
